// ==== hw/tsdr_pkg.sv ====
// Package for the trigger sequencer data register bank
package tsdr_pkg;
   localparam int DW = 16;
   localparam int QW = 8;
   localparam int PW = 5;

   // Register byte addresses
   localparam logic [7:0] A_T0LIM = 8'h00;
   localparam logic [7:0] A_T1LIM = 8'h04;
   localparam logic [7:0] A_SDLIM = 8'h08;
   localparam logic [7:0] A_C0LIM = 8'h0C;
   localparam logic [7:0] A_C1LIM = 8'h10;
   localparam logic [7:0] A_HOLD  = 8'h14;
   localparam logic [7:0] A_ADJ   = 8'h18;
   localparam logic [7:0] A_LIT   = 8'h1C;
   localparam logic [7:0] A_QPTR  = 8'h20;
   localparam logic [7:0] A_CTRL  = 8'h24;
   localparam logic [7:0] A_STAT  = 8'h28;
   localparam logic [7:0] A_CHSEL = 8'h2C;
   localparam logic [7:0] A_QUE0  = 8'h40;
   localparam logic [7:0] A_QEND  = 8'h5C;

   // Control register fields
   localparam int CTRL_EN  = 0;
   localparam int CTRL_RUN = 1;

   // Command codes (upper nibble; jumps use the top three bits)
   localparam logic [3:0] CMD_CTRL = 4'h0;
   localparam logic [3:0] CMD_ADD  = 4'h1;
   localparam logic [2:0] CMD_JMP  = 3'b101;
   localparam logic [2:0] CMD_JC0  = 3'b110;
   localparam logic [2:0] CMD_JC1  = 3'b111;

   // Control options, and the add command's copy option
   localparam logic [3:0] OPT_SD_OFF = 4'h2;
   localparam logic [3:0] OPT_SD_ON  = 4'h6;
   localparam logic [3:0] OPT_T0     = 4'h8;
   localparam logic [3:0] OPT_T1     = 4'h9;
   localparam logic [3:0] OPT_CH_C0  = 4'hC;
   localparam logic [3:0] OPT_CH_C1  = 4'hD;
   localparam logic [3:0] OPT_CH_LIT = 4'hE;
   localparam logic [3:0] OPT_COPY   = 4'h8;

   localparam logic [DW-1:0] RST_VAL = 16'h0000;

   typedef enum {ST_IDLE, ST_EXEC, ST_WAIT, ST_DELAY} tsdr_state_t;

   typedef struct packed {
      logic [DW-1:0] t0lim;
      logic [DW-1:0] t1lim;
      logic [DW-1:0] sdlim;
      logic [DW-1:0] c0lim;
      logic [DW-1:0] c1lim;
      logic [DW-1:0] hold;
      logic [DW-1:0] adj;
      logic [DW-1:0] lit;
      logic [PW-1:0] qptr;
      logic          en;
      logic          run;
      logic          sd_en;
      logic [DW-1:0] cnt0;
      logic [DW-1:0] cnt1;
      logic [DW-1:0] tmr;
      logic [DW-1:0] dly;
      logic          wait_t1;
      logic [DW-1:0] chsel;
      tsdr_state_t   st;
      logic          pready;
      logic          pslverr;
      logic [31:0]   prdata;
   } tsdr_regs_t;
endpackage

// ==== hw/tsdr_top.sv ====
// Trigger sequencer data registers with step engine and APB slave
`timescale 1ns/1ps
module tsdr_top
   import tsdr_pkg::*;
(
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   // Converter channel select
   output logic      [DW-1:0] converter_channel_select
);
   tsdr_regs_t r;
   tsdr_regs_t next_r;
   logic [DW-1:0] queue [QW];
   logic [DW-1:0] next_qword;
   logic          q_we;
   logic [2:0]    q_idx;
   logic          locked;
   logic [7:0]    step_byte;
   logic [3:0]    opt;
   logic [DW-1:0] operand;
   logic [DW-1:0] tgt_new;

   assign prdata                   = r.prdata;
   assign pready                   = r.pready;
   assign pslverr                  = r.pslverr;
   assign converter_channel_select = r.chsel;

   always_ff @(posedge pclk) begin
      if (q_we) begin
         queue[q_idx] <= next_qword;
      end
   end

   always_comb begin
      step_byte = r.qptr[0] ? queue[r.qptr[3:1]][15:8]
                            : queue[r.qptr[3:1]][7:0];
   end

   always_comb begin
      logic          acc;
      logic          wr;
      logic [31:0]   rd;
      acc = 1'b0;
      wr = 1'b0;
      rd = 32'h0000_0000;
      next_r = r;
      q_we = 1'b0;
      q_idx = paddr[4:2];
      next_qword = pwdata[DW-1:0];
      opt = step_byte[3:0];
      locked = r.en & r.run;
      acc = psel & penable & ~r.pready;
      wr = acc & pwrite & ~locked;
      // Add and copy share one code; option bit 3 picks copy
      operand = opt[3] ? r.hold : r.adj;
      tgt_new = RST_VAL;
      next_r.pready = acc;
      next_r.pslverr = 1'b0;

      // Software register access
      if (acc) begin
         case (paddr)
            A_T0LIM: rd[DW-1:0] = r.t0lim;
            A_T1LIM: rd[DW-1:0] = r.t1lim;
            A_SDLIM: rd[DW-1:0] = r.sdlim;
            A_C0LIM: rd[DW-1:0] = r.c0lim;
            A_C1LIM: rd[DW-1:0] = r.c1lim;
            A_HOLD:  rd[DW-1:0] = r.hold;
            A_ADJ:   rd[DW-1:0] = r.adj;
            A_LIT:   rd[DW-1:0] = r.lit;
            A_QPTR:  rd[PW-1:0] = r.qptr;
            A_CTRL:  rd[1:0] = {r.run, r.en};
            A_STAT:  rd[2:0] = {r.sd_en, (r.st != ST_IDLE), locked};
            A_CHSEL: rd[DW-1:0] = r.chsel;
            default: begin
               if (paddr >= A_QUE0 && paddr <= A_QEND && paddr[1:0] == 2'b00)
               begin
                  rd[DW-1:0] = queue[paddr[4:2]];
               end else begin
                  next_r.pslverr = 1'b1;
               end
            end
         endcase
         next_r.prdata = rd;
         if (wr) begin
            case (paddr)
               A_T0LIM: next_r.t0lim = pwdata[DW-1:0];
               A_T1LIM: next_r.t1lim = pwdata[DW-1:0];
               A_SDLIM: next_r.sdlim = pwdata[DW-1:0];
               A_C0LIM: next_r.c0lim = pwdata[DW-1:0];
               A_C1LIM: next_r.c1lim = pwdata[DW-1:0];
               A_HOLD:  next_r.hold  = pwdata[DW-1:0];
               A_ADJ:   next_r.adj   = pwdata[DW-1:0];
               A_LIT:   next_r.lit   = pwdata[DW-1:0];
               A_QPTR:  next_r.qptr  = pwdata[PW-1:0];
               default: begin
                  if (paddr >= A_QUE0 && paddr <= A_QEND
                      && paddr[1:0] == 2'b00) begin
                     q_we = 1'b1;
                  end
               end
            endcase
         end
         // Control is always writable so software can stop the engine
         if (pwrite && paddr == A_CTRL) begin
            next_r.en  = pwdata[CTRL_EN];
            next_r.run = pwdata[CTRL_RUN];
         end
      end

      // Step engine
      case (r.st)
         ST_IDLE: begin
            if (locked) begin
               next_r.st = ST_EXEC;
            end
         end
         ST_EXEC: begin
            next_r.st = ST_DELAY;
            next_r.dly = RST_VAL;
            next_r.qptr = r.qptr + 5'h01;
            if (step_byte[7:4] == CMD_CTRL) begin
               case (opt)
                  OPT_SD_OFF: next_r.sd_en = 1'b0;
                  OPT_SD_ON:  next_r.sd_en = 1'b1;
                  OPT_T0, OPT_T1: begin
                     next_r.tmr = RST_VAL;
                     next_r.wait_t1 = opt[0];
                     next_r.st = ST_WAIT;
                  end
                  OPT_CH_C0:  next_r.chsel = r.cnt0;
                  OPT_CH_C1:  next_r.chsel = r.cnt1;
                  OPT_CH_LIT: next_r.chsel = r.lit;
                  default: ;
               endcase
            end else if (step_byte[7:4] == CMD_ADD) begin
               case (opt[2:0])
                  3'd0: tgt_new = r.c0lim;
                  3'd1: tgt_new = r.c1lim;
                  3'd2: tgt_new = r.t0lim;
                  3'd3: tgt_new = r.t1lim;
                  3'd4: tgt_new = r.sdlim;
                  3'd5: tgt_new = r.lit;
                  default: tgt_new = RST_VAL;
               endcase
               if (!opt[3]) begin
                  tgt_new = tgt_new + operand;
               end else begin
                  tgt_new = operand;
               end
               // Options 6 and 7 of either half are reserved no-ops
               if (opt[2:0] <= 3'd5) begin
                  case (opt[2:0])
                     3'd0: next_r.c0lim = tgt_new;
                     3'd1: next_r.c1lim = tgt_new;
                     3'd2: next_r.t0lim = tgt_new;
                     3'd3: next_r.t1lim = tgt_new;
                     3'd4: next_r.sdlim = tgt_new;
                     3'd5: next_r.lit   = tgt_new;
                     default: ;
                  endcase
               end
            end else if (step_byte[7:5] == CMD_JMP) begin
               next_r.qptr = step_byte[4:0];
            end else if (step_byte[7:5] == CMD_JC0) begin
               if (r.cnt0 == r.c0lim) begin
                  next_r.cnt0 = RST_VAL;
               end else begin
                  next_r.cnt0 = r.cnt0 + 16'h0001;
                  next_r.qptr = step_byte[4:0];
               end
            end else if (step_byte[7:5] == CMD_JC1) begin
               if (r.cnt1 == r.c1lim) begin
                  next_r.cnt1 = RST_VAL;
               end else begin
                  next_r.cnt1 = r.cnt1 + 16'h0001;
                  next_r.qptr = step_byte[4:0];
               end
            end
         end
         ST_WAIT: begin
            next_r.tmr = r.tmr + 16'h0001;
            if (r.tmr == (r.wait_t1 ? r.t1lim : r.t0lim)) begin
               next_r.st = ST_DELAY;
            end
         end
         ST_DELAY: begin
            // step delay is limit plus one, or one cycle while step delay is off
            next_r.dly = r.dly + 16'h0001;
            if (!r.sd_en || r.dly == r.sdlim) begin
               next_r.st = ST_IDLE;
            end
         end
         default: next_r.st = ST_IDLE;
      endcase
      if (!locked && r.st != ST_IDLE) begin
         next_r.st = ST_IDLE;
      end
   end

   // reset clears all but the queue
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule

// ==== testbench/tsdr_properties.sv ====
// Port checks for the trigger sequencer data register bank
`timescale 1ns/1ps
module tsdr_properties
   import tsdr_pkg::*;
(
   // Clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // APB slave
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [7:0]    paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   // Converter channel select
   input wire logic [DW-1:0] converter_channel_select
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_ok;
   assign rd_ok = pready && !pwrite && !pslverr;
   property p_answer;
      psel && penable && !pready |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long pready");
   property p_in_access;
      pready |-> psel && penable;
   endproperty
   a_in_access: assert property (p_in_access) else $error("stray pready");
   property p_err_pair;
      pslverr |-> pready;
   endproperty
   a_err_pair: assert property (p_err_pair) else $error("stray error");
   property p_unmapped;
      pready && pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("bad data");
   property p_mapped;
      pready && paddr[1:0] == 2'b00 && paddr <= A_CHSEL |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped) else $error("bad error");
   property p_qptr;
      rd_ok && paddr == A_QPTR |-> prdata[31:5] == 27'h0;
   endproperty
   a_qptr: assert property (p_qptr) else $error("pointer upper");
   property p_width;
      rd_ok && (paddr < A_QPTR || paddr >= A_QUE0) |-> prdata[31:16] == 16'h0;
   endproperty
   a_width: assert property (p_width) else $error("upper half set");
   property p_reset;
      $rose(presetn) |-> converter_channel_select == 16'h0000;
   endproperty
   a_reset: assert property (p_reset) else $error("select not clear");
   cover property (rd_ok && paddr == A_QPTR);
   cover property (pslverr);
   cover property (converter_channel_select != 16'h0000);
endmodule

// ==== testbench/tb_trigger_sequencer_data_registers.sv ====
// Self-checking bench for the trigger sequencer data register bank
`timescale 1ns/1ps
module tb_trigger_sequencer_data_registers
   import tsdr_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tsdr_row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] chsel;
   logic [31:0] r;
   logic        err;
   int          fail_count = 0;
   int          compares = 0;
   int          cycles = 0;
   tsdr_row_t   rows [11] = '{
      '{A_T0LIM, 32'h0001A5A5, 32'h0000A5A5}, '{A_T1LIM, 32'hFFFF5A5A, 32'h5A5A},
      '{A_SDLIM, 32'h1, 32'h1}, '{A_C0LIM, 32'h8001, 32'h8001},
      '{A_C1LIM, 32'h7FFE, 32'h7FFE}, '{A_HOLD, 32'h0123, 32'h0123},
      '{A_ADJ, 32'h0010, 32'h0010}, '{A_LIT, 32'hFFFF, 32'hFFFF},
      '{A_QPTR, 32'hFFFF, 32'h1F}, '{A_QUE0, 32'h151D, 32'h151D},
      '{8'h44, 32'hA30E, 32'hA30E}};
   tsdr_top dut (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .paddr                    (paddr),
      .pwdata                   (pwdata),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .converter_channel_select (chsel)
   );
   always #4 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic end_of_test();
      $display("Checks: %0d, mismatches: %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i <= 8; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(r, 32'h0);
      end
      for (int i = 0; i < 11; i++) begin
         apb(1'b1, rows[i].a, rows[i].w);
         apb(1'b0, rows[i].a, 32'h0);
         chk(r, rows[i].e);
      end
      apb(1'b1, 8'h30, 32'hFFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h30, 32'h0);
      chk(r, 32'h0);
      // Copy to literal, add to literal, literal to select, then park
      apb(1'b1, A_QPTR, 32'h0);
      apb(1'b1, A_CTRL, 32'h3);
      for (int i = 0; i < 200 && chsel !== 16'h0133; i++) @(posedge pclk);
      chk({16'h0, chsel}, 32'h0133);
      apb(1'b0, A_LIT, 32'h0);
      chk(r, 32'h0133);
      apb(1'b1, A_T0LIM, 32'h1234);
      apb(1'b0, A_T0LIM, 32'h0);
      chk(r, 32'hA5A5);
      apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_T0LIM, 32'h1234);
      apb(1'b0, A_T0LIM, 32'h0);
      chk(r, 32'h1234);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_QUE0, 32'h0);
      chk(r, 32'h151D);
      apb(1'b0, A_HOLD, 32'h0);
      chk(r, 32'h0);
      end_of_test();
   end
endmodule
bind tsdr_top tsdr_properties u_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .converter_channel_select(converter_channel_select));
